//--- logic/flash_clock_and_option_regs.v
// flash clock divider, option shadow, key unlock and security state
// assumes a single-cycle register port and a sequencer asking for
// program and erase operations of a given pulse count
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "flash_clk_opt_defs.vh"
module flash_clock_and_option_regs #(
    parameter PULSE_WIDTH = 16
) (
    input  wire                   clk,
    input  wire                   reset,
    input  wire                   clkEn,
    input  wire [15:0]            regAddr,
    input  wire [7:0]             regWrData,
    input  wire                   regWr,
    input  wire                   regRd,
    output reg  [7:0]             regRdData,
    input  wire                   accessDebug,
    input  wire                   accessFromUnsecured,
    input  wire                   accessToSecure,
    output wire                   memAccessBlocked,
    input  wire                   testMode,
    input  wire                   commandDoneFlag,
    input  wire [7:0]             nonvolatileOptionByte,
    input  wire [63:0]            storedUnlockKey,
    input  wire                   keyAccessMode,
    input  wire                   blankCheckPass,
    input  wire                   opStart,
    input  wire [PULSE_WIDTH-1:0] opPulses,
    output wire                   opAccepted,
    output wire                   opRefused,
    output reg                    opBusy,
    output reg                    opDone,
    output wire                   flashTimingStrobe,
    output wire                   divisorLoadedFlag,
    output wire                   keyUnlockEnable,
    output wire                   redirectDisable,
    output wire [1:0]             securityCode,
    output wire                   deviceSecured
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    reg                   divLoaded_q;
    reg                   prescaleLocked_q;
    reg                   prescale_q;
    reg  [5:0]            divisor_q;
    reg                   optLoad_q;
    reg  [7:0]            optShadow_q;
    reg  [1:0]            secCode_q;
    reg  [3:0]            keyIdx_q;
    reg                   keyOk_q;
    reg                   keyAccPrev_q;
    reg  [PULSE_WIDTH-1:0] pulseCnt_q;
    reg  [7:0]            rdData_d;
    reg  [1:0]            opState_q;
    wire [7:0]            keyLaneMatch;
    genvar                g;

    localparam [1:0]      OP_IDLE   = 2'h0;
    localparam [1:0]      OP_RUN    = 2'h1;
    localparam [1:0]      OP_FINISH = 2'h2;

    wire                  freeAccess;
    wire                  wrDiv;
    wire                  keyWr;
    wire                  keyByteMatch;
    wire                  keyAccFall;
    wire                  keyUnlock;
    wire                  secured;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // location +0 is the most significant byte of storedUnlockKey
    function [7:0] keyByte;
        input [63:0] key;
        input integer idx;
        begin
            keyByte = key[8*(7-idx) +: 8];
        end
    endfunction

    function isSecCodeOpen;
        input [1:0] code;
        begin
            isSecCodeOpen = (code == `SEC_UNSECURED);
        end
    endfunction

    function isUntrustedAccess;
        input sec;
        input dbg;
        input unsec;
        begin
            isUntrustedAccess = sec && (dbg || unsec);
        end
    endfunction

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    assign secured = !isSecCodeOpen(secCode_q);
    assign freeAccess = testMode && commandDoneFlag;
    assign wrDiv = regWr && (regAddr == `CLK_DIV_ADDR) && !optLoad_q;
    // debug or unsecured-code key writes never advance the compare
    assign keyWr = regWr && keyAccessMode && !optLoad_q
                   && ((regAddr & `KEY_ADDR_MASK) == `KEY_BASE_ADDR)
                   && !accessDebug && !accessFromUnsecured;
    assign keyByteMatch = (regAddr[2:0] == keyIdx_q[2:0])
                          && (keyIdx_q < `KEY_BYTES)
                          && keyLaneMatch[regAddr[2:0]];

    // one comparator per key location; the address picks the lane
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_keyLane
            assign keyLaneMatch[g] = (regWrData == keyByte(storedUnlockKey, g));
        end
    endgenerate

    assign keyAccFall = keyAccPrev_q && !keyAccessMode;
    assign keyUnlock = keyAccFall && keyOk_q && (keyIdx_q == `KEY_BYTES)
                       && optShadow_q[`KEY_ENABLE_BIT];

    assign memAccessBlocked = accessToSecure
                              && isUntrustedAccess(secured, accessDebug, accessFromUnsecured);

    // -------------------------------------------------------------
    // clock divider register
    // -------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            divLoaded_q      <= 1'b0;
            prescaleLocked_q <= 1'b0;
            prescale_q       <= 1'b0;
            divisor_q        <= 6'h00;
        end else if (clkEn && wrDiv) begin
            if (freeAccess) begin
                divLoaded_q <= regWrData[`DIV_LOADED_BIT];
                prescale_q  <= regWrData[`PRESCALE_BIT];
                divisor_q   <= regWrData[`DIVISOR_MSB:0];
            end else begin
                divLoaded_q      <= 1'b1;
                divisor_q        <= regWrData[`DIVISOR_MSB:0];
                prescaleLocked_q <= 1'b1;
                if (!prescaleLocked_q) begin
                    prescale_q <= regWrData[`PRESCALE_BIT];
                end
            end
        end
    end

    assign divisorLoadedFlag = divLoaded_q;

    // -------------------------------------------------------------
    // timing strobe generator
    // -------------------------------------------------------------
    flash_clock_divider_core #(
        .DIV_WIDTH(6)
    ) divider (
        .clk            (clk),
        .reset          (reset),
        .clkEn          (clkEn),
        .enable         (divLoaded_q),
        .prescaleByEight(prescale_q),
        .divisor        (divisor_q),
        .timingStrobe   (flashTimingStrobe)
    );

    // -------------------------------------------------------------
    // program and erase pulse counting
    // -------------------------------------------------------------
    assign opAccepted = opStart && !opBusy && divLoaded_q;
    assign opRefused  = opStart && (opBusy || !divLoaded_q);

    // busy and done are plain decodes of the state register
    always @* begin
        opBusy = (opState_q == OP_RUN);
        opDone = (opState_q == OP_FINISH);
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            opState_q  <= OP_IDLE;
            pulseCnt_q <= {PULSE_WIDTH{1'b0}};
        end else if (clkEn) begin
            case (opState_q)
                OP_IDLE, OP_FINISH: begin
                    // a start may follow the done cycle directly
                    if (opAccepted) begin
                        opState_q  <= OP_RUN;
                        pulseCnt_q <= opPulses;
                    end else begin
                        opState_q <= OP_IDLE;
                    end
                end
                OP_RUN: begin
                    if (!divLoaded_q) begin
                        // test-mode clear of the flag aborts the operation
                        opState_q <= OP_FINISH;
                    end else if (flashTimingStrobe) begin
                        // whole pulses only; a count of zero ends on first pulse
                        if (pulseCnt_q <= {{(PULSE_WIDTH-1){1'b0}}, 1'b1}) begin
                            opState_q  <= OP_FINISH;
                            pulseCnt_q <= {PULSE_WIDTH{1'b0}};
                        end else begin
                            pulseCnt_q <= pulseCnt_q - {{(PULSE_WIDTH-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default: begin
                    opState_q <= OP_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // option shadow and security state
    // -------------------------------------------------------------
    // the option byte is a port, so it is caught on the first
    // enabled edge after release rather than inside the reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            optLoad_q   <= 1'b1;
            optShadow_q <= `OPT_RESET;
            secCode_q   <= 2'h3;
        end else if (clkEn) begin
            if (optLoad_q) begin
                optLoad_q   <= 1'b0;
                optShadow_q <= nonvolatileOptionByte & `OPT_USED_MASK;
                secCode_q   <= nonvolatileOptionByte[1:0];
            end
            // unlock only after the load cycle; an event on the load edge is dropped
            if (!optLoad_q && (keyUnlock || blankCheckPass)) begin
                secCode_q <= `SEC_UNSECURED;
            end
        end
    end

    assign keyUnlockEnable = optShadow_q[`KEY_ENABLE_BIT];
    assign redirectDisable = optShadow_q[`REDIRECT_DIS_BIT];
    assign securityCode    = secCode_q;
    assign deviceSecured   = secured;

    // -------------------------------------------------------------
    // backdoor key compare
    // -------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            keyIdx_q     <= 4'h0;
            keyOk_q      <= 1'b0;
            keyAccPrev_q <= 1'b0;
        end else if (clkEn) begin
            keyAccPrev_q <= keyAccessMode;
            if (keyAccessMode && !keyAccPrev_q) begin
                keyIdx_q <= 4'h0;
                keyOk_q  <= 1'b1;
            end else if (keyWr) begin
                // out-of-order or wrong byte spoils the attempt
                if (!keyByteMatch) begin
                    keyOk_q <= 1'b0;
                end
                if (keyIdx_q != 4'hF) begin
                    keyIdx_q <= keyIdx_q + 4'h1;
                end
            end else if (keyAccFall) begin
                keyOk_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    always @* begin
        rdData_d = 8'h00;
        case (regAddr)
            `CLK_DIV_ADDR: begin
                rdData_d = {divLoaded_q, prescale_q, divisor_q};
            end
            `OPT_SHADOW_ADDR: begin
                // writes here fall through to nothing
                rdData_d = {optShadow_q[7:2], secCode_q};
            end
            `NV_OPT_ADDR: begin
                if (!isUntrustedAccess(secured, accessDebug, accessFromUnsecured)) begin
                    rdData_d = nonvolatileOptionByte & `OPT_USED_MASK;
                end else begin
                    rdData_d = 8'h00;
                end
            end
            default: begin
                rdData_d = 8'h00;
            end
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= regRd ? rdData_d : 8'h00;
        end
    end
endmodule

//--- logic/flash_clk_opt_defs.vh
// constants for the flash clock divider and option register block
// assumes byte-wide registers on a 16-bit address map
//
// Contract
// - loaded flag: reset clear, set on first write
// - no program or erase while flag clear
// - prescale bit writable once in user mode
// - prescale bit one divides bus clock by eight
// - flash clock equals input over divisor plus one
// - timing pulse is one flash clock cycle
// - test mode with done flag: all freely writable
// - option shadow loaded from option byte at reset; here on the first enabled edge after reset release
// - option bits five to two read zero
// - option shadow writes ignored, reads always allowed
// - key enable zero: never unlock by key
// - key writes count only from secure firmware
// - eight ascending matching key bytes unlock until reset
// - redirect disable bit one turns redirection off
// - security code 10 unsecured, match sets 10
// - secured: blocked writes dropped, reads return zero
`ifndef FLASH_CLK_OPT_DEFS_VH
`define FLASH_CLK_OPT_DEFS_VH

// -----------------------------------------------------------------
// addresses
// -----------------------------------------------------------------
`define CLK_DIV_ADDR     16'h1820
`define OPT_SHADOW_ADDR  16'h1821
`define NV_OPT_ADDR      16'hFFBF
`define KEY_BASE_ADDR    16'hFFB0
`define KEY_ADDR_MASK    16'hFFF8

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DIV_LOADED_BIT   7
`define PRESCALE_BIT     6
`define DIVISOR_MSB      5
`define KEY_ENABLE_BIT   7
`define REDIRECT_DIS_BIT 6
`define OPT_USED_MASK    8'hC3

// -----------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------
`define CLK_DIV_RESET    8'h00
`define OPT_RESET        8'h00
`define SEC_UNSECURED    2'h2
`define PRESCALE_RATIO   3'h7
`define KEY_BYTES        4'h8

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FCLK_MIN_KHZ     150
`define FCLK_MAX_KHZ     200

`endif

//--- logic/flash_clock_divider_core.v
// prescaler and reloading down-counter for the flash timing clock
// assumes clkEn freezes counting along with the rest of the block
`timescale 1ns/1ns
`include "flash_clk_opt_defs.vh"
module flash_clock_divider_core #(
    parameter DIV_WIDTH = 6
) (
    input  wire                 clk,
    input  wire                 reset,
    input  wire                 clkEn,
    input  wire                 enable,
    input  wire                 prescaleByEight,
    input  wire [DIV_WIDTH-1:0] divisor,
    output reg                  timingStrobe
);
    reg  [2:0]           preCnt_q;
    reg  [DIV_WIDTH-1:0] divCnt_q;
    wire                 divTick;

    // -------------------------------------------------------------
    // divide-by-eight prescaler
    // -------------------------------------------------------------
    assign divTick = !prescaleByEight || (preCnt_q == `PRESCALE_RATIO);

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            preCnt_q     <= 3'h0;
            divCnt_q     <= {DIV_WIDTH{1'b0}};
            timingStrobe <= 1'b0;
        end else if (clkEn) begin
            if (!enable) begin
                preCnt_q     <= 3'h0;
                divCnt_q     <= {DIV_WIDTH{1'b0}};
                timingStrobe <= 1'b0;
            end else begin
                preCnt_q     <= preCnt_q + 3'h1;
                timingStrobe <= 1'b0;
                if (divTick) begin
                    // reload on zero: period is divisor plus one ticks
                    if (divCnt_q == {DIV_WIDTH{1'b0}}) begin
                        divCnt_q     <= divisor;
                        timingStrobe <= 1'b1;
                    end else begin
                        divCnt_q <= divCnt_q - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end
endmodule

//--- sim/flash_clock_and_option_regs_chk.sv
// checker for the flash clock divider and option register block
// assumes a single clock domain; the bench drops clkEn only in test mode
`timescale 1ns/1ns
module flash_clock_and_option_regs_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] regAddr,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdData,
    input wire logic        accessDebug,
    input wire logic        accessFromUnsecured,
    input wire logic        accessToSecure,
    input wire logic        memAccessBlocked,
    input wire logic        testMode,
    input wire logic        opStart,
    input wire logic        opAccepted,
    input wire logic        opRefused,
    input wire logic        opBusy,
    input wire logic        flashTimingStrobe,
    input wire logic        divisorLoadedFlag,
    input wire logic        keyUnlockEnable,
    input wire logic        redirectDisable,
    input wire logic [1:0]  securityCode,
    input wire logic        deviceSecured,
    input wire logic        blankCheckPass
);
    // ---------------------------------------------
    // cycles since reset; first cycle loads options
    // ---------------------------------------------
    logic [1:0] upCnt_q;
    always @(posedge clk or posedge reset) begin
        if (reset) upCnt_q <= 2'h0;
        else if (upCnt_q != 2'h2) upCnt_q <= upCnt_q + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_sec_code: assert property (deviceSecured == (securityCode != 2'h2))
        else $error("secured output disagrees with code");
    a_blocked_access: assert property (memAccessBlocked == (deviceSecured && accessToSecure
        && (accessDebug || accessFromUnsecured)))
        else $error("blocking wrong");
    a_opt_read_zero: assert property ($past(regRd) && $past(regAddr) == 16'h1821
        |-> regRdData[5:2] == 4'h0)
        else $error("unused option bits not zero");
    a_opt_stable: assert property (upCnt_q == 2'h2
        |-> $stable(keyUnlockEnable) && $stable(redirectDisable))
        else $error("option shadow changed after load");
    a_flag_set: assert property (upCnt_q != 2'h0 && regWr && regAddr == 16'h1820
        && !testMode |=> divisorLoadedFlag)
        else $error("loaded flag not set by write");
    a_flag_hold: assert property (divisorLoadedFlag && !testMode |=> divisorLoadedFlag)
        else $error("loaded flag cleared in user mode");
    a_key_off: assert property (upCnt_q != 2'h0 && !keyUnlockEnable && !blankCheckPass
        && deviceSecured |=> deviceSecured)
        else $error("unlocked with key disabled");
    a_strobe_off: assert property (!divisorLoadedFlag && !$past(divisorLoadedFlag)
        |-> !flashTimingStrobe)
        else $error("strobe before divider written");
    a_refuse_flag: assert property (opStart && !divisorLoadedFlag
        |-> opRefused && !opAccepted)
        else $error("operation not refused");
    a_refuse_busy: assert property (opStart && opBusy |-> opRefused && !opAccepted)
        else $error("start accepted while busy");
    a_accept_busy: assert property (opAccepted |=> opBusy)
        else $error("accepted operation not busy");
endmodule

bind flash_clock_and_option_regs flash_clock_and_option_regs_chk i_chk (.*);

//--- sim/tb.sv
// self-checking bench for the flash clock and option registers
// assumes the register port answers reads in the following cycle
`timescale 1ns/1ns
module tb;
    logic        clk = 0, reset = 1, clkEn = 1, regWr = 0, regRd = 0, opStart = 0;
    logic        accessDebug = 0, accessFromUnsecured = 0, accessToSecure = 0;
    logic        testMode = 0, commandDoneFlag = 0, keyAccessMode = 0, blankCheckPass = 0;
    logic [15:0] regAddr = 16'h0000, opPulses = 16'h0001;
    logic [7:0]  regWrData = 8'h00, nonvolatileOptionByte = 8'hFF, mDiv;
    logic [63:0] storedUnlockKey = 64'h0;
    wire  [7:0]  regRdData;
    wire  [1:0]  securityCode;
    wire         memAccessBlocked, opAccepted, opRefused, opBusy, opDone, deviceSecured;
    wire         flashTimingStrobe, divisorLoadedFlag, keyUnlockEnable, redirectDisable;
    int          n_mismatch = 0, checked = 0;
    bit          mFirst;
    always #5 clk = ~clk;
    flash_clock_and_option_regs i_flash_clock_and_option_regs (.*);
    // ---------------------------------------------
    // bus tasks and model
    // ---------------------------------------------
    task chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        // prescale is write-once outside test mode
        if (a == 16'h1820 && testMode && commandDoneFlag) mDiv = d;
        else if (a == 16'h1820) begin
            mDiv = {1'b1, mFirst ? d[6] : mDiv[6], d[5:0]};
            mFirst = 0;
        end
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask
    task rst(input logic [7:0] nv);
        @(posedge clk);
        reset <= 1'b1;
        nonvolatileOptionByte <= nv;
        mDiv = 8'h00;
        mFirst = 1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // first two periods may run on a stale count
    task period(input int e);
        int n, k;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (flashTimingStrobe !== 1'b1 && n < 600);
        end
        chk(n, e);
    endtask
    task runop(input int p);
        int n, k;
        @(posedge clk);
        opStart <= 1'b1;
        opPulses <= 16'(p);
        #1;
        chk(opAccepted, 1'b1);
        @(posedge clk);
        #1;
        chk(opRefused, 1'b1);
        n = (opBusy === 1'b1 && flashTimingStrobe === 1'b1);
        k = 0;
        while (opDone !== 1'b1 && k < 2000) begin
            @(posedge clk);
            opStart <= 1'b0;
            #1;
            k++;
            if (opBusy === 1'b1 && flashTimingStrobe === 1'b1) n++;
        end
        chk(n, p);
        chk({opDone, opBusy}, 2'h2);
    endtask
    task keys(input logic dbg);
        int i;
        @(posedge clk);
        keyAccessMode <= 1'b1;
        accessDebug <= dbg;
        repeat (2) @(posedge clk);
        for (i = 0; i < 8; i++) wr({13'h1FF6, i[2:0]}, storedUnlockKey[63-8*i -: 8]);
        @(posedge clk);
        keyAccessMode <= 1'b0;
        accessDebug <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task give_verdict;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        void'($urandom(32'hFED3));
        storedUnlockKey <= {$urandom(), $urandom()};
        rst(8'hFF);
        rd(16'h1821, 8'hC3);
        chk({keyUnlockEnable, redirectDisable, securityCode}, 4'hF);
        wr(16'h1821, 8'($urandom()));
        rd(16'h1821, 8'hC3);
        rd(16'h1820, 8'h00);
        @(posedge clk);
        opStart <= 1'b1;
        #1;
        chk({opRefused, opAccepted}, 2'h2);
        @(posedge clk);
        opStart <= 1'b0;
        wr(16'h1820, 8'h02);
        rd(16'h1820, mDiv);
        period(3);
        wr(16'h1820, 8'h43);
        rd(16'h1820, mDiv);
        period(4);
        runop($urandom_range(4, 1));
        @(posedge clk);
        accessToSecure <= 1'b1;
        accessDebug <= 1'b1;
        #1;
        chk(memAccessBlocked, 1'b1);
        rd(16'hFFBF, 8'h00);
        @(posedge clk);
        accessDebug <= 1'b0;
        accessFromUnsecured <= 1'b1;
        #1;
        chk(memAccessBlocked, 1'b1);
        @(posedge clk);
        accessFromUnsecured <= 1'b0;
        accessToSecure <= 1'b0;
        keys(1);
        chk(securityCode, 2'h3);
        keys(0);
        chk(securityCode, 2'h2);
        @(posedge clk);
        accessDebug <= 1'b1;
        accessToSecure <= 1'b1;
        #1;
        chk(memAccessBlocked, 1'b0);
        rd(16'hFFBF, 8'hC3);
        @(posedge clk);
        accessDebug <= 1'b0;
        accessToSecure <= 1'b0;
        rst(8'h3F);
        rd(16'h1821, 8'h03);
        chk({keyUnlockEnable, redirectDisable}, 2'h0);
        keys(0);
        chk(securityCode, 2'h3);
        @(posedge clk);
        blankCheckPass <= 1'b1;
        @(posedge clk);
        blankCheckPass <= 1'b0;
        #1;
        chk(deviceSecured, 1'b0);
        @(posedge clk);
        testMode <= 1'b1;
        commandDoneFlag <= 1'b1;
        wr(16'h1820, 8'h45);
        rd(16'h1820, mDiv);
        wr(16'h1820, 8'hC1);
        rd(16'h1820, mDiv);
        period(16);
        // a write with clkEn low must leave the register untouched
        @(posedge clk);
        clkEn <= 1'b0;
        regAddr <= 16'h1820;
        regWrData <= 8'h02;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        clkEn <= 1'b1;
        rd(16'h1820, mDiv);
        // 100 MHz / (8 * 63) keeps the flash clock in range
        wr(16'h1820, 8'hFE);
        rd(16'h1820, mDiv);
        period(504);
        give_verdict;
    end
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end
endmodule
